// file: logic/ddr2_init_pkg.sv
// Purpose: Shared constants and types for the memory-side mode register block
// Assumes: Address bus is 14 bits, bank address 3 bits
// Notes:   Field structs follow the address-pin order of each register word
package ddr2_init_pkg;

	localparam int ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam int COL_W  = 10;
	localparam int LOCK_W = 8;

	// Clocks the DLL needs after enable and reset
	localparam logic [LOCK_W-1:0] DLL_LOCK_CLKS = 8'hc8;

	// Command pin codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MODE  = 4'h0;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ  = 4'h5;

	// Bank address codes selecting the register on a mode write
	localparam logic [1:0] SEL_MODE = 2'h0;
	localparam logic [1:0] SEL_EXT1 = 2'h1;

	// Burst length codes
	localparam logic [2:0] BL_FOUR  = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;

	// Auto precharge / precharge-all address bit
	localparam int AP_BIT = 10;

	// Values after reset
	localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;
	localparam logic [ADDR_W-1:0] EXT1_RST = 14'h0001;

	typedef enum logic [2:0] {
		PWR_UP   = 3'b001,
		PWR_RUN  = 3'b010,
		PWR_SELF = 3'b100
	} pwr_e;

	typedef struct packed {
		logic       cs_n;
		logic       ras_n;
		logic       cas_n;
		logic       we_n;
	} cmd_s;

	typedef struct packed {
		logic [1:0] rsv;
		logic [2:0] wr;
		logic       dll_rst;
		logic       test;
		logic [2:0] cl;
		logic       bt;
		logic [2:0] bl;
	} mode_s;

	typedef struct packed {
		logic [1:0] rsv;
		logic       rdqs_en;
		logic       dqs_dis;
		logic [2:0] ocd;
		logic       rtt_hi;
		logic [2:0] al;
		logic       rtt_lo;
		logic       weak_drv;
		logic       dll_dis;
	} ext1_s;

endpackage

// file: logic/ddr2_mode_regs.sv
// Purpose: Command decode, mode register storage and DLL lock tracking inside the memory
// Assumes: All inputs synchronous to clk_sys; controller keeps its own ordering duties
// Notes:   Array data path is not modelled; bank state, latched addresses and flags are
//
// Functional notes
// RULE1 - Access needs Active before Read or Write
// RULE2 - Active latches bank and row address
// RULE3 - Read/Write latches start column and auto-precharge
// RULE4 - Controller holds clock enable, termination low
// RULE5 - Controller waits 200us, then raises clock enable
// RULE6 - Controller waits 400ns, then precharge all
// RULE7 - Controller writes extended registers two, three
// RULE8 - Controller writes extended one, DLL enabled
// RULE9 - Controller resets DLL through mode write
// RULE10 - Precharge all, two refreshes, final mode write
// RULE11 - Driver calibration default then exit, 200 clocks
// RULE12 - Every register write supplies all fields
// RULE13 - Register writes leave array contents untouched
// RULE14 - Mode write: all command pins low
// RULE15 - Mode writes only with banks idle; open banks are flagged on base mode register writes only
// RULE16 - Low mode bits select burst four/eight
// RULE17 - Remaining mode register field layout
// RULE18 - Write recovery programmed as rounded cycles
// RULE19 - Extended one write: bank bit zero high
// RULE20 - Extended register one field layout
// RULE21 - Self refresh turns DLL off, exit on
// RULE22 - No Read for 200 clocks after reset
`timescale 1ns/1ns
module ddr2_mode_regs #(
	parameter int LOCK_CLKS = 200
) (
	input  wire logic                                clk_sys,
	input  wire logic                                rstn,
	input  wire logic                                ce,
	input  wire logic                                cke,
	input  wire ddr2_init_pkg::cmd_s                 cmd,
	input  wire logic [ddr2_init_pkg::BANK_W-1:0]    ba,
	input  wire logic [ddr2_init_pkg::ADDR_W-1:0]    addr,
	output ddr2_init_pkg::mode_s                     mode_word,
	output ddr2_init_pkg::ext1_s                     ext1_word,
	output logic                                     burst_eight,
	output logic [7:0]                               banks_open,
	output logic [ddr2_init_pkg::BANK_W-1:0]         row_bank,
	output logic [ddr2_init_pkg::ADDR_W-1:0]         row_addr,
	output logic [ddr2_init_pkg::BANK_W-1:0]         col_bank,
	output logic [ddr2_init_pkg::COL_W-1:0]          col_start,
	output logic                                     auto_pre,
	output logic                                     col_write,
	output logic                                     dll_on,
	output logic                                     dll_locked,
	output logic                                     self_ref,
	output logic                                     access_err,
	output logic                                     cfg_err
);

	typedef struct packed {
		ddr2_init_pkg::pwr_e                      pwr;
		logic                                     cke_q;
		ddr2_init_pkg::mode_s                     mode;
		ddr2_init_pkg::ext1_s                     ext1;
		logic                                     bl8;
		logic [7:0]                               open;
		logic [ddr2_init_pkg::BANK_W-1:0]         rbank;
		logic [ddr2_init_pkg::ADDR_W-1:0]         row;
		logic [ddr2_init_pkg::BANK_W-1:0]         cbank;
		logic [ddr2_init_pkg::COL_W-1:0]          col;
		logic                                     ap;
		logic                                     wr;
		logic [ddr2_init_pkg::LOCK_W-1:0]         lock_cnt;
		logic                                     locked;
		logic                                     aerr;
		logic                                     cerr;
		logic                                     sref;
		logic                                     dllon;
	} state_s;

	localparam logic [ddr2_init_pkg::LOCK_W-1:0] LOCK_LOAD = ddr2_init_pkg::LOCK_W'(LOCK_CLKS);

	state_s st_reg;
	state_s st_next;
	logic   live;
	logic   [3:0] code;

	// Commands count only while clock enable was and is high
	assign live = st_reg.cke_q && cke && !cmd.cs_n;
	assign code = cmd;

	// Next-state logic; register writes touch only register state, never bank contents
	always_comb begin
		st_next = st_reg;
		st_next.cke_q = cke;
		// Lock countdown only runs while the DLL has a clock to track
		if (st_reg.lock_cnt != '0 && st_reg.pwr != ddr2_init_pkg::PWR_SELF) begin
			st_next.lock_cnt = st_reg.lock_cnt - 1'b1;
			st_next.locked   = (st_reg.lock_cnt == 8'h01) && !st_reg.ext1.dll_dis;
		end
		case (st_reg.pwr)
			ddr2_init_pkg::PWR_UP: begin
				if (cke) begin
					st_next.pwr = ddr2_init_pkg::PWR_RUN;
				end
			end
			ddr2_init_pkg::PWR_RUN: begin
				// Refresh with clock enable falling enters self refresh, DLL off
				if (st_reg.cke_q && !cke && !cmd.cs_n && code == ddr2_init_pkg::CMD_REF) begin
					st_next.pwr      = ddr2_init_pkg::PWR_SELF; // see RULE21
					st_next.locked   = 1'b0;
					st_next.lock_cnt = '0;
				end
			end
			ddr2_init_pkg::PWR_SELF: begin
				// DLL restarts on exit and must relock before reads
				if (cke) begin
					st_next.pwr      = ddr2_init_pkg::PWR_RUN; // see RULE21
					st_next.lock_cnt = LOCK_LOAD;
					st_next.locked   = 1'b0;
				end
			end
			default: begin
				st_next.pwr = ddr2_init_pkg::PWR_UP;
			end
		endcase
		if (live && st_reg.pwr == ddr2_init_pkg::PWR_RUN) begin
			case (code)
				ddr2_init_pkg::CMD_MODE: begin // see RULE13
					// Whole word is replaced on every mode or extended-one write
					if (ba[1:0] == ddr2_init_pkg::SEL_MODE && ba[2] == 1'b0) begin
						st_next.mode = addr; // see RULE14, RULE12, RULE17
						st_next.bl8  = (addr[2:0] == ddr2_init_pkg::BL_EIGHT); // see RULE16
						if ((addr[2:0] != ddr2_init_pkg::BL_FOUR && addr[2:0] != ddr2_init_pkg::BL_EIGHT)
							|| addr[7] || st_reg.open != 8'h00) begin
							st_next.cerr = 1'b1; // see RULE16
						end
						if (addr[8] && !st_reg.ext1.dll_dis) begin
							st_next.lock_cnt = LOCK_LOAD; // see RULE22
							st_next.locked   = 1'b0;
						end
					end else if (ba[1:0] == ddr2_init_pkg::SEL_EXT1 && ba[2] == 1'b0) begin
						st_next.ext1 = addr; // see RULE19, RULE20
						if (addr[0]) begin
							st_next.locked   = 1'b0;
							st_next.lock_cnt = '0;
						end
					end
				end
				ddr2_init_pkg::CMD_ACT: begin
					st_next.open[ba] = 1'b1;
					st_next.rbank    = ba; // see RULE2
					st_next.row      = addr; // see RULE2
				end
				ddr2_init_pkg::CMD_READ, ddr2_init_pkg::CMD_WRITE: begin
					st_next.cbank = ba;
					st_next.col   = addr[ddr2_init_pkg::COL_W-1:0]; // see RULE3
					st_next.ap    = addr[ddr2_init_pkg::AP_BIT]; // see RULE3
					st_next.wr    = (code == ddr2_init_pkg::CMD_WRITE);
					// Access to an idle bank, or a read before lock, is flagged
					if (!st_reg.open[ba] || (code == ddr2_init_pkg::CMD_READ && !st_reg.locked)) begin
						st_next.aerr = 1'b1; // see RULE1
					end
					if (addr[ddr2_init_pkg::AP_BIT]) begin
						st_next.open[ba] = 1'b0;
					end
				end
				ddr2_init_pkg::CMD_PRE: begin
					if (addr[ddr2_init_pkg::AP_BIT]) begin
						st_next.open = 8'h00;
					end else begin
						st_next.open[ba] = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Decodes are registered here so every output leaves a flip-flop
		st_next.sref  = (st_next.pwr == ddr2_init_pkg::PWR_SELF); // see RULE21
		st_next.dllon = !st_next.ext1.dll_dis && !st_next.sref; // see RULE21
	end

	// Single state register; ce low freezes everything
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_reg          <= '0;
			st_reg.pwr      <= ddr2_init_pkg::PWR_UP;
			st_reg.mode     <= ddr2_init_pkg::MODE_RST;
			st_reg.ext1     <= ddr2_init_pkg::EXT1_RST;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign mode_word   = st_reg.mode;
	assign ext1_word   = st_reg.ext1;
	assign burst_eight = st_reg.bl8;
	assign banks_open  = st_reg.open;
	assign row_bank    = st_reg.rbank;
	assign row_addr    = st_reg.row;
	assign col_bank    = st_reg.cbank;
	assign col_start   = st_reg.col;
	assign auto_pre    = st_reg.ap;
	assign col_write   = st_reg.wr;
	assign dll_on      = st_reg.dllon;
	assign dll_locked  = st_reg.locked;
	assign self_ref    = st_reg.sref;
	assign access_err  = st_reg.aerr;
	assign cfg_err     = st_reg.cerr;

	// Checks on the decoded behaviour
	logic run_cmd;
	assign run_cmd = ce && live && st_reg.pwr == ddr2_init_pkg::PWR_RUN;

	row_latch_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE2
		run_cmd && code == ddr2_init_pkg::CMD_ACT |=> row_addr == $past(addr) && banks_open[$past(ba)])
		else $error("Active did not latch bank and row");
	col_latch_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE3
		run_cmd && code == ddr2_init_pkg::CMD_WRITE |=> col_write && auto_pre == $past(addr[10]))
		else $error("Write did not latch column or auto precharge");
	idle_access_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE1
		run_cmd && code == ddr2_init_pkg::CMD_WRITE && !banks_open[ba] |=> access_err)
		else $error("Write to idle bank not flagged");
	mode_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE14
		run_cmd && code == ddr2_init_pkg::CMD_MODE && ba == 3'h0 |=> mode_word == $past(addr))
		else $error("Mode write not stored");
	ext1_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE19
		run_cmd && code == ddr2_init_pkg::CMD_MODE && ba == 3'h1 |=> ext1_word == $past(addr) && $stable(mode_word))
		else $error("Extended write wrong target");
	burst_len_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE16
		run_cmd && code == ddr2_init_pkg::CMD_MODE && ba == 3'h0 && addr[2:0] == 3'h3 |=> burst_eight)
		else $error("Burst eight not decoded");
	array_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE13
		run_cmd && code == ddr2_init_pkg::CMD_MODE |=> $stable(banks_open) && $stable(row_addr))
		else $error("Register write disturbed bank state");
	// Check helper: enabled cycles since the lock count was last loaded; the wait is too long for a repetition
	logic [15:0] lock_age;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lock_age <= 16'h0000;
		end else if (ce && st_next.lock_cnt == LOCK_LOAD) begin
			lock_age <= 16'h0000;
		end else if (ce && lock_age != 16'hffff) begin
			lock_age <= lock_age + 16'h0001;
		end
	end

	lock_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE22
		$rose(dll_locked) |-> lock_age >= 16'(LOCK_CLKS))
		else $error("DLL locked too early");
	self_dll_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE21
		self_ref |-> !dll_on && !dll_locked)
		else $error("DLL running in self refresh");
	cfg_test_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE17
		run_cmd && code == ddr2_init_pkg::CMD_MODE && ba == 3'h0 && addr[7] |=> cfg_err)
		else $error("Test mode bit not flagged");

	act_seen_c: cover property (@(posedge clk_sys) run_cmd && code == ddr2_init_pkg::CMD_ACT);
	lock_done_c: cover property (@(posedge clk_sys) $rose(dll_locked));
	self_exit_c: cover property (@(posedge clk_sys) $fell(self_ref));

endmodule

// file: tb/ddr2_ctrl_model.sv
// Purpose: Controller-side model driving clock enable, command and address
// Assumes: Drives at falling clk_sys; the device only samples at rising edges
// Notes:   Power-up waits are shortened through parameters to keep runs short
`timescale 1ns/1ns
module ddr2_ctrl_model #(
	parameter int LOCK_CLKS = 8,
	parameter int PWR_CLKS  = 20
) (
	input  wire logic                        clk_sys,
	output ddr2_init_pkg::cmd_s              cmd,
	output logic                             ce,
	output logic                             cke,
	output logic [ddr2_init_pkg::BANK_W-1:0] ba,
	output logic [ddr2_init_pkg::ADDR_W-1:0] addr
);
	// Clock enable held low while power settles
	initial begin
		ce = 1'b1;
		cke = 1'b0;
		cmd = 4'hf;
		ba = 3'h0;
		addr = 14'h0000;
	end
	// One command cycle, then deselect with inverted lines so stale values never match
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic [1:0] en);
		@(negedge clk_sys);
		cmd <= c;
		ba <= b;
		addr <= a;
		{ce, cke} <= en;
		@(negedge clk_sys);
		cmd <= ~c | 4'h8;
		ba <= ~b;
		addr <= ~a;
		ce <= 1'b1;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wake();
		@(negedge clk_sys);
		cke <= 1'b1;
		idle(1);
	endtask
	// Power-up through the DLL reset write
	task automatic init_a();
		idle(PWR_CLKS);
		cke <= 1'b1;
		idle(100);
		issue(ddr2_init_pkg::CMD_PRE, 3'h0, 14'h0400, 2'b11);
		issue(ddr2_init_pkg::CMD_MODE, 3'h2, 14'h0000, 2'b11);
		issue(ddr2_init_pkg::CMD_MODE, 3'h3, 14'h0000, 2'b11);
		issue(ddr2_init_pkg::CMD_MODE, 3'h1, 14'h0000, 2'b11);
		issue(ddr2_init_pkg::CMD_MODE, 3'h0, 14'h0542, 2'b11);
	endtask
	// Refreshes, operating mode, then driver calibration once the DLL has locked
	task automatic init_b();
		issue(ddr2_init_pkg::CMD_PRE, 3'h0, 14'h0400, 2'b11);
		repeat (2) issue(ddr2_init_pkg::CMD_REF, 3'h0, 14'h0000, 2'b11);
		issue(ddr2_init_pkg::CMD_MODE, 3'h0, 14'h044b, 2'b11);
		idle(LOCK_CLKS);
		issue(ddr2_init_pkg::CMD_MODE, 3'h1, 14'h038c, 2'b11);
		issue(ddr2_init_pkg::CMD_MODE, 3'h1, 14'h000c, 2'b11);
	endtask
endmodule

// file: tb/ddr2_mode_regs_test.sv
// Purpose: Self-checking bench for the mode register block
// Assumes: Controller model drives all command inputs at falling edges
// Notes:   Expectations are queued with a due cycle and checked by a monitor
`timescale 1ns/1ns
module ddr2_mode_regs_test;
	typedef struct {logic [3:0] k; logic [31:0] v; int due;} note_s;
	logic                 clk_sys, rstn, ce, cke, burst_eight, auto_pre, col_write;
	logic                 dll_on, dll_locked, self_ref, access_err, cfg_err;
	ddr2_init_pkg::cmd_s  cmd;
	ddr2_init_pkg::mode_s mode_word;
	ddr2_init_pkg::ext1_s ext1_word;
	logic [2:0]           ba, row_bank, col_bank, rb;
	logic [13:0]          addr, row_addr, ra;
	logic [9:0]           col_start, ca;
	logic [7:0]           banks_open;
	note_s                q[$];
	note_s                n;
	int                   cyc = 0, n_errors = 0, checks = 0;
	integer               seed = 32'h093b;
	string nm[11] = '{"mode","ext1","bl8","banks","row","col","dll_on","locked","sref","acc_err","cfg_err"};
	ddr2_ctrl_model #(.LOCK_CLKS(8), .PWR_CLKS(20)) ddr2_ctrl_model_i (.clk_sys(clk_sys), .cmd(cmd),
		.ce(ce), .cke(cke), .ba(ba), .addr(addr));
	ddr2_mode_regs #(.LOCK_CLKS(8)) ddr2_mode_regs_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .cke(cke),
		.cmd(cmd), .ba(ba), .addr(addr), .mode_word(mode_word), .ext1_word(ext1_word),
		.burst_eight(burst_eight), .banks_open(banks_open), .row_bank(row_bank), .row_addr(row_addr),
		.col_bank(col_bank), .col_start(col_start), .auto_pre(auto_pre), .col_write(col_write),
		.dll_on(dll_on), .dll_locked(dll_locked), .self_ref(self_ref), .access_err(access_err),
		.cfg_err(cfg_err));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] got(input logic [3:0] k);
		case (k)
			4'h0: got = 32'(mode_word);
			4'h1: got = 32'(ext1_word);
			4'h2: got = 32'(burst_eight);
			4'h3: got = 32'(banks_open);
			4'h4: got = 32'({row_bank, row_addr});
			4'h5: got = 32'({col_bank, col_start, auto_pre, col_write});
			4'h6: got = 32'(dll_on);
			4'h7: got = 32'(dll_locked);
			4'h8: got = 32'(self_ref);
			4'h9: got = 32'(access_err);
			default: got = 32'(cfg_err);
		endcase
	endfunction
	task automatic note(input logic [3:0] k, input logic [31:0] v);
		q.push_back('{k, v, cyc + 1});
	endtask
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Due notes are checked at falling edges, after the rising-edge updates have landed
	always @(negedge clk_sys) begin
		cyc <= cyc + 1;
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			cmp(nm[n.k], n.v, got(n.k));
		end
	end
	// Long enough for power-up, programming and the access scenarios
	initial begin
		#8000;
		n_errors++;
		end_of_test();
	end
	initial begin
		rstn = 1'b0;
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		note(4'h0, 32'h0);
		note(4'h1, 32'h1);
		note(4'h6, 32'h0);
		ddr2_ctrl_model_i.init_a();
		note(4'h0, 32'h0542);
		note(4'h1, 32'h0);
		note(4'h2, 32'h0);
		note(4'h6, 32'h1);
		note(4'h7, 32'h0);
		ddr2_ctrl_model_i.init_b();
		note(4'h0, 32'h044b);
		note(4'h1, 32'h000c);
		note(4'h2, 32'h1);
		note(4'h7, 32'h1);
		rb = 3'($random(seed));
		ra = 14'($random(seed));
		ca = 10'($random(seed));
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_ACT, rb, ra, 2'b11);
		note(4'h3, 32'(8'h01 << rb));
		note(4'h4, {15'h0, rb, ra});
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_WRITE, rb, {4'h0, ca}, 2'b11);
		note(4'h5, {17'h0, rb, ca, 2'b01});
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_READ, rb, {4'h1, ca}, 2'b11);
		note(4'h5, {17'h0, rb, ca, 2'b10});
		note(4'h3, 32'h0);
		note(4'h9, 32'h0);
		// ce low with clock enable still high must swallow the command
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_ACT, 3'h5, ra, 2'b01);
		note(4'h3, 32'h0);
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_MODE, 3'h2, ~ra, 2'b11);
		note(4'h0, 32'h044b);
		note(4'h1, 32'h000c);
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_MODE, 3'h0, 14'h0449, 2'b11);
		note(4'ha, 32'h1);
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_REF, 3'h0, 14'h0000, 2'b10);
		note(4'h8, 32'h1);
		note(4'h6, 32'h0);
		ddr2_ctrl_model_i.wake();
		note(4'h8, 32'h0);
		note(4'h6, 32'h1);
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_ACT, 3'h0, ra, 2'b11);
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_READ, 3'h0, 14'h0000, 2'b11);
		note(4'h9, 32'h1);
		ddr2_ctrl_model_i.idle(2);
		// Mid-run reset must restore the chosen reset values and clear the sticky flags
		rstn = 1'b0;
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		note(4'h0, 32'h0);
		note(4'h1, 32'h1);
		note(4'h3, 32'h0);
		note(4'h6, 32'h0);
		note(4'h9, 32'h0);
		note(4'ha, 32'h0);
		// Test-mode bit alone, burst length legal and banks idle, must be flagged
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_MODE, 3'h0, 14'h04cb, 2'b11);
		note(4'h0, 32'h04cb);
		note(4'ha, 32'h1);
		// Write with no Active before it
		ddr2_ctrl_model_i.issue(ddr2_init_pkg::CMD_WRITE, 3'h7, 14'h0000, 2'b11);
		note(4'h9, 32'h1);
		ddr2_ctrl_model_i.idle(4);
		end_of_test();
	end
endmodule
